//--- src/sideband_pkg.sv
// Purpose: Shared constants for the sideband error and control block
// Assumes: Single system bus clock, synchronous active-high reset
// Notes: All pins active high at the ports; pad inversion is external
package sideband_pkg;
  // Widths
  localparam int VID_W = 5;
  localparam int BUS_RATIO_SELECT_OUT_W = 2;
  localparam int SYNC_STAGES = 3;
  // Flush sequencer
  localparam logic [15:0] LINE_COUNT_DEF = 16'h0100;
  // Power-on configuration bit positions
  localparam int CFG_FLUSH_BIT = 0;
  localparam int CFG_BIST_BIT = 1;
  localparam int CFG_W = 2;
  // Bus transaction codes
  localparam logic [1:0] TXN_NONE = 2'h0;
  localparam logic [1:0] TXN_FLUSH_ACK = 2'h1;
  localparam logic [1:0] TXN_SHUTDOWN = 2'h2;
  // Flush state machine
  typedef enum logic [3:0] {
    FL_IDLE = 4'h1,
    FL_WBACK = 4'h2,
    FL_INVAL = 4'h4,
    FL_ACK = 4'h8
  } flush_state_t;
endpackage

//--- src/pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input is asynchronous to clk_sys_in
// Notes: Output changes once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // Pin
  input wire logic async_in,
  output logic sync_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Hold last agreed value while stages disagree
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      sync_out <= RESET_VAL;
    end else if (s2_q == s3_q) begin
      sync_out <= s3_q;
    end
  end
endmodule // pin_sync

//--- src/cpu_sideband_error_control.sv
// Summary of operation
// RULE1 - Gate low floats voltage code and bus ratio outputs; high drives them.
// RULE2 - Float fault output asserts on any unmasked floating-point error.
// RULE3 - Purge request writes back modified lines, then invalidates all lines.
// RULE4 - After purge completes, issue a Flush Acknowledge bus transaction.
// RULE5 - No cache allocation while the purge request stays asserted.
// RULE6 - Agent keeps purge valid by target ready of the I/O write.
// RULE7 - Purge input sampled at reset release into power-on configuration.
// RULE8 - Both snoop lines together request or extend a snoop stall.
// RULE9 - Internal error asserts internal fault and issues a SHUTDOWN. Here the SHUTDOWN is issued only while internal fault is low.
// RULE10 - Internal fault holds until reset, bus restart or warm restart.
// RULE11 - Suppress asserted: ignore pending numeric errors, keep executing.
// RULE12 - Suppress deasserted: prior error raises exception on next FP op.
// RULE13 - Numeric-report bit set makes suppress input irrelevant.
// RULE14 - Agent keeps suppress valid by target ready of the I/O write.
// RULE15 - Warm restart resets integer registers, keeps caches and FP state. Here warm restart also clears the pending FP error.
// RULE16 - After warm restart, resume at configured reset vector.
// RULE17 - Snoops keep being serviced during warm restart.
// RULE18 - Warm restart active at reset release requests self-test.
// RULE19 - Asynchronous sideband inputs pass a synchroniser before use. Power-on configuration samples the raw purge and warm restart pins.
//
// Purpose: Sideband control and error reporting toward core logic
// Assumes: Cache walk and core hooks are simple handshakes from the core
// Notes: Pins are active high here; pad logic provides the inversion
`timescale 1ns/1ps
module cpu_sideband_error_control #(
  parameter logic [15:0] LINE_COUNT = sideband_pkg::LINE_COUNT_DEF,
  parameter logic [sideband_pkg::VID_W-1:0] VOLTAGE_CODE = 5'h0A,
  parameter logic [sideband_pkg::BUS_RATIO_SELECT_OUT_W-1:0] BUS_RATIO = 2'h1
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // Identification outputs
  input wire logic id_output_gate_in,
  output logic [sideband_pkg::VID_W-1:0] voltage_code_out,
  output logic [sideband_pkg::VID_W-1:0] voltage_code_oe_out,
  output logic [sideband_pkg::BUS_RATIO_SELECT_OUT_W-1:0] bus_ratio_select_out,
  output logic [sideband_pkg::BUS_RATIO_SELECT_OUT_W-1:0] bus_ratio_select_oe_out,
  // Asynchronous sideband pins
  input wire logic cache_purge_in,
  input wire logic numeric_fault_suppress_in,
  input wire logic warm_restart_in,
  input wire logic bus_level_restart_in,
  // Floating-point core hooks
  input wire logic cr0_numeric_report_bit_in,
  input wire logic fp_error_in,
  input wire logic fp_error_masked_in,
  input wire logic fp_noncontrol_op_in,
  output logic float_fault_out,
  output logic fp_exception_out,
  // Internal error
  input wire logic internal_error_in,
  output logic internal_fault_out,
  // Cache walk hooks
  input wire logic line_modified_in,
  input wire logic line_done_in,
  output logic [15:0] line_index_out,
  output logic line_writeback_out,
  output logic line_invalidate_out,
  output logic cache_alloc_block_out,
  // Bus special transaction request
  input wire logic txn_ready_in,
  output logic txn_valid_out,
  output logic [1:0] txn_code_out,
  // Snoop
  input wire logic snoop_req_in,
  input wire logic snoop_hit_in,
  input wire logic snoop_dirty_in,
  input wire logic snoop_busy_in,
  output logic snoop_match_out,
  output logic snoop_match_oe_out,
  output logic snoop_dirty_match_out,
  output logic snoop_dirty_match_oe_out,
  // Core restart
  output logic int_regs_reset_out,
  output logic fetch_reset_vector_out,
  output logic [sideband_pkg::CFG_W-1:0] poweron_cfg_out
);
  initial begin
    if (LINE_COUNT == 16'h0000) $error("LINE_COUNT must be nonzero");
  end

  // ********************************
  // Synchronisers
  // ********************************
  logic purge_s;
  logic suppress_s;
  logic warm_s;
  logic bus_level_restart_s;

  // RULE19 synchronise all pins
  pin_sync u_sync_purge (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .async_in(cache_purge_in), .sync_out(purge_s));
  pin_sync u_sync_supp (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .async_in(numeric_fault_suppress_in), .sync_out(suppress_s));
  pin_sync u_sync_warm (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .async_in(warm_restart_in), .sync_out(warm_s));
  pin_sync u_sync_bus_level_restart (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .async_in(bus_level_restart_in), .sync_out(bus_level_restart_s));

  // ********************************
  // Identification outputs
  // ********************************
  logic gate_s;
  pin_sync u_sync_gate (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .async_in(id_output_gate_in), .sync_out(gate_s));

  // RULE1 float unless gated on
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      voltage_code_oe_out <= '0;
      bus_ratio_select_oe_out <= '0;
      voltage_code_out <= '0;
      bus_ratio_select_out <= '0;
    end else begin
      voltage_code_out <= VOLTAGE_CODE;
      bus_ratio_select_out <= BUS_RATIO;
      voltage_code_oe_out <= {sideband_pkg::VID_W{gate_s}};
      bus_ratio_select_oe_out <= {sideband_pkg::BUS_RATIO_SELECT_OUT_W{gate_s}};
    end
  end

  // ********************************
  // Power-on configuration
  // ********************************
  logic rst_d1_q;
  always_ff @(posedge clk_sys_in) begin
    rst_d1_q <= srst_in;
  end

  // RULE7 RULE18 sample at release
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      poweron_cfg_out <= '0;
    end else if (rst_d1_q) begin
      poweron_cfg_out[sideband_pkg::CFG_FLUSH_BIT] <= cache_purge_in;
      poweron_cfg_out[sideband_pkg::CFG_BIST_BIT] <= warm_restart_in;
    end
  end

  // ********************************
  // Floating point error
  // ********************************
  logic fp_pending_q;
  logic suppress_eff;
  // RULE13 report bit overrides suppress
  assign suppress_eff = suppress_s && !cr0_numeric_report_bit_in;

  // RULE2 unmasked error latches
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || warm_s) begin
      fp_pending_q <= 1'b0;
    end else if (fp_error_in && !fp_error_masked_in) begin
      fp_pending_q <= 1'b1;
    end else if (fp_noncontrol_op_in && !suppress_eff) begin
      fp_pending_q <= 1'b0;
    end
  end
  assign float_fault_out = fp_pending_q;

  // RULE11 RULE12 exception gating
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      fp_exception_out <= 1'b0;
    end else begin
      fp_exception_out <= fp_pending_q && fp_noncontrol_op_in &&
                          !suppress_eff;
    end
  end

  // ********************************
  // Internal error
  // ********************************
  logic shutdown_req_q;
  logic shutdown_done;
  logic ack_done;

  // RULE10 sticky until restart
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || bus_level_restart_s || warm_s) begin
      internal_fault_out <= 1'b0;
    end else if (internal_error_in) begin
      internal_fault_out <= 1'b1;
    end
  end

  // RULE9 shutdown transaction
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      shutdown_req_q <= 1'b0;
    end else if (internal_error_in && !internal_fault_out) begin
      shutdown_req_q <= 1'b1;
    end else if (shutdown_done) begin
      shutdown_req_q <= 1'b0;
    end
  end

  // ********************************
  // Cache purge sequencer
  // ********************************
  sideband_pkg::flush_state_t fl_q;
  logic purge_prev_q;
  logic last_line;
  assign last_line = (line_index_out == LINE_COUNT - 16'h0001);

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      purge_prev_q <= 1'b0;
    end else begin
      purge_prev_q <= purge_s;
    end
  end

  // RULE3 write back then invalidate
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      fl_q <= sideband_pkg::FL_IDLE;
      line_index_out <= '0;
    end else begin
      unique case (fl_q)
        sideband_pkg::FL_IDLE: begin
          line_index_out <= '0;
          if (purge_s && !purge_prev_q) begin
            fl_q <= sideband_pkg::FL_WBACK;
          end
        end
        sideband_pkg::FL_WBACK: begin
          if (line_done_in || !line_modified_in) begin
            line_index_out <= last_line ? 16'h0000 :
                              line_index_out + 16'h0001;
            if (last_line) begin
              fl_q <= sideband_pkg::FL_INVAL;
            end
          end
        end
        sideband_pkg::FL_INVAL: begin
          line_index_out <= last_line ? 16'h0000 :
                            line_index_out + 16'h0001;
          if (last_line) begin
            fl_q <= sideband_pkg::FL_ACK;
          end
        end
        sideband_pkg::FL_ACK: begin
          // RULE4 acknowledge transaction
          if (ack_done) begin
            fl_q <= sideband_pkg::FL_IDLE;
          end
        end
      endcase
    end
  end

  assign line_writeback_out = (fl_q == sideband_pkg::FL_WBACK) &&
                              line_modified_in;
  assign line_invalidate_out = (fl_q == sideband_pkg::FL_INVAL);
  // RULE5 block allocation
  assign cache_alloc_block_out = purge_s || (fl_q != sideband_pkg::FL_IDLE);

  // ********************************
  // Special transaction issue
  // ********************************
  // Flush ack wins; a pending shutdown follows next
  always_comb begin
    txn_valid_out = 1'b0;
    txn_code_out = sideband_pkg::TXN_NONE;
    if (fl_q == sideband_pkg::FL_ACK) begin
      txn_valid_out = 1'b1;
      txn_code_out = sideband_pkg::TXN_FLUSH_ACK;
    end else if (shutdown_req_q) begin
      txn_valid_out = 1'b1;
      txn_code_out = sideband_pkg::TXN_SHUTDOWN;
    end
  end
  assign ack_done = txn_valid_out && txn_ready_in &&
                    (txn_code_out == sideband_pkg::TXN_FLUSH_ACK);
  assign shutdown_done = txn_valid_out && txn_ready_in &&
                         (txn_code_out == sideband_pkg::TXN_SHUTDOWN);

  // ********************************
  // Snoop results
  // ********************************
  // RULE8 RULE17 stall or report, warm restart ignored
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      snoop_match_out <= 1'b0;
      snoop_dirty_match_out <= 1'b0;
      snoop_match_oe_out <= 1'b0;
      snoop_dirty_match_oe_out <= 1'b0;
    end else begin
      // Dirty hit drives the dirty line alone, else it reads as a stall
      snoop_match_out <= snoop_req_in &&
                         (snoop_busy_in || (snoop_hit_in && !snoop_dirty_in));
      snoop_dirty_match_out <= snoop_req_in &&
                               (snoop_busy_in || snoop_dirty_in);
      snoop_match_oe_out <= snoop_req_in;
      snoop_dirty_match_oe_out <= snoop_req_in;
    end
  end

  // ********************************
  // Warm restart
  // ********************************
  logic warm_prev_q;
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      warm_prev_q <= 1'b0;
    end else begin
      warm_prev_q <= warm_s;
    end
  end

  // RULE15 integer state only
  assign int_regs_reset_out = warm_s;

  // RULE16 restart at reset vector
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      fetch_reset_vector_out <= 1'b0;
    end else begin
      fetch_reset_vector_out <= warm_prev_q && !warm_s;
    end
  end

  // ********************************
  // Assertions
  // ********************************
  sequence s_err_seen;
    internal_error_in && !bus_level_restart_s && !warm_s;
  endsequence

  // Fault holds absent restart
  AST_INTERNAL_FAULT_OUT_STICKY: assert property (@(posedge clk_sys_in) // RULE10
    disable iff (srst_in)
    internal_fault_out && !bus_level_restart_s && !warm_s |=> internal_fault_out)
    else $error("internal fault dropped without restart");

  AST_INTERNAL_FAULT_OUT_SET: assert property (@(posedge clk_sys_in) // RULE9
    disable iff (srst_in) s_err_seen |=> internal_fault_out)
    else $error("internal fault not raised");

  AST_INTERNAL_FAULT_OUT_CLEAR: assert property (@(posedge clk_sys_in) // RULE10
    disable iff (srst_in) warm_s || bus_level_restart_s |=> !internal_fault_out)
    else $error("internal fault not cleared by restart");

  AST_GATE: assert property (@(posedge clk_sys_in) // RULE1
    disable iff (srst_in)
    !gate_s |=> voltage_code_oe_out == '0 && bus_ratio_select_oe_out == '0)
    else $error("id outputs driven while gate low");

  AST_FLOAT_FAULT_OUT: assert property (@(posedge clk_sys_in) // RULE2
    disable iff (srst_in || warm_s)
    fp_error_in && !fp_error_masked_in |=> float_fault_out)
    else $error("float fault missing");

  AST_NOEXC: assert property (@(posedge clk_sys_in) // RULE11
    disable iff (srst_in)
    suppress_s && !cr0_numeric_report_bit_in |=> !fp_exception_out)
    else $error("exception raised while suppressed");

  AST_NE_OVERRIDE: assert property (@(posedge clk_sys_in) // RULE13
    disable iff (srst_in)
    fp_pending_q && fp_noncontrol_op_in && cr0_numeric_report_bit_in
    |=> fp_exception_out)
    else $error("report bit did not override suppress");

  AST_ALLOC: assert property (@(posedge clk_sys_in) // RULE5
    disable iff (srst_in) purge_s |-> cache_alloc_block_out)
    else $error("allocation allowed during purge");

  AST_ACK_ORDER: assert property (@(posedge clk_sys_in) // RULE4
    disable iff (srst_in)
    txn_code_out == sideband_pkg::TXN_FLUSH_ACK |->
    $past(fl_q) == sideband_pkg::FL_INVAL || $past(fl_q) == fl_q)
    else $error("flush ack before walk finished");

  AST_STALL: assert property (@(posedge clk_sys_in) // RULE8
    disable iff (srst_in)
    snoop_req_in && snoop_busy_in |=>
    snoop_match_out && snoop_dirty_match_out)
    else $error("snoop stall not signalled");
endmodule // cpu_sideband_error_control

//--- tb/cache_bus_partner.sv
// Purpose: Far-side model of the cache walk and bus transaction acceptor
// Assumes: Same clock as the block; random stall lengths from $urandom
// Notes: Odd line indices hold modified data
`timescale 1ns/1ps
module cache_bus_partner (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // Cache walk
  input wire logic [15:0] line_index_in,
  input wire logic line_writeback_in,
  output logic line_modified_out,
  output logic line_done_out,
  // Bus transaction
  input wire logic txn_valid_in,
  output logic txn_ready_out
);
  logic [1:0] wb_wait_q;
  logic [1:0] tx_wait_q;
  assign line_modified_out = line_index_in[0];
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || !line_writeback_in || line_done_out) begin
      wb_wait_q <= 2'($urandom_range(3, 0));
      line_done_out <= 1'b0;
    end else if (wb_wait_q == 2'h0) begin
      line_done_out <= 1'b1;
    end else begin
      wb_wait_q <= wb_wait_q - 2'h1;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || !txn_valid_in || txn_ready_out) begin
      tx_wait_q <= 2'($urandom_range(3, 0));
      txn_ready_out <= 1'b0;
    end else if (tx_wait_q == 2'h0) begin
      txn_ready_out <= 1'b1;
    end else begin
      tx_wait_q <= tx_wait_q - 2'h1;
    end
  end
endmodule // cache_bus_partner

//--- tb/tb_cpu_sideband_error_control.sv
// Purpose: Self-checking bench for the sideband error and control block
// Assumes: Outputs sampled one ns after the rising edge
// Notes: Four-line cache keeps the purge walk short
`timescale 1ns/1ps
module tb_cpu_sideband_error_control;
  logic clk_sys_in, srst_in, id_output_gate_in, cache_purge_in;
  logic numeric_fault_suppress_in, warm_restart_in, bus_level_restart_in;
  logic cr0_numeric_report_bit_in, fp_error_in, fp_error_masked_in;
  logic fp_noncontrol_op_in, float_fault_out, fp_exception_out;
  logic internal_error_in, internal_fault_out, line_modified_in;
  logic line_done_in, line_writeback_out, line_invalidate_out;
  logic cache_alloc_block_out, txn_ready_in, txn_valid_out;
  logic snoop_req_in, snoop_hit_in, snoop_dirty_in, snoop_busy_in;
  logic snoop_match_out, snoop_dirty_match_out;
  logic snoop_match_oe_out, snoop_dirty_match_oe_out;
  logic int_regs_reset_out, fetch_reset_vector_out;
  logic [4:0] voltage_code_out, voltage_code_oe_out;
  logic [1:0] bus_ratio_select_out, bus_ratio_select_oe_out, txn_code_out;
  logic [1:0] poweron_cfg_out, last_code;
  logic [15:0] line_index_out;
  int bad_count, tests_run, wb_cnt, inv_cnt, txn_cnt, c0, i, k;
  logic sup, ne;

  cpu_sideband_error_control #(.LINE_COUNT(16'h0004),
    .VOLTAGE_CODE(5'h15), .BUS_RATIO(2'h2)) cpu_sideband_error_control_i (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .id_output_gate_in(id_output_gate_in),
    .voltage_code_out(voltage_code_out),
    .voltage_code_oe_out(voltage_code_oe_out),
    .bus_ratio_select_out(bus_ratio_select_out),
    .bus_ratio_select_oe_out(bus_ratio_select_oe_out),
    .cache_purge_in(cache_purge_in),
    .numeric_fault_suppress_in(numeric_fault_suppress_in),
    .warm_restart_in(warm_restart_in),
    .bus_level_restart_in(bus_level_restart_in),
    .cr0_numeric_report_bit_in(cr0_numeric_report_bit_in),
    .fp_error_in(fp_error_in), .fp_error_masked_in(fp_error_masked_in),
    .fp_noncontrol_op_in(fp_noncontrol_op_in),
    .float_fault_out(float_fault_out), .fp_exception_out(fp_exception_out),
    .internal_error_in(internal_error_in),
    .internal_fault_out(internal_fault_out),
    .line_modified_in(line_modified_in), .line_done_in(line_done_in),
    .line_index_out(line_index_out), .line_writeback_out(line_writeback_out),
    .line_invalidate_out(line_invalidate_out),
    .cache_alloc_block_out(cache_alloc_block_out),
    .txn_ready_in(txn_ready_in), .txn_valid_out(txn_valid_out),
    .txn_code_out(txn_code_out), .snoop_req_in(snoop_req_in),
    .snoop_hit_in(snoop_hit_in), .snoop_dirty_in(snoop_dirty_in),
    .snoop_busy_in(snoop_busy_in), .snoop_match_out(snoop_match_out),
    .snoop_match_oe_out(snoop_match_oe_out),
    .snoop_dirty_match_out(snoop_dirty_match_out),
    .snoop_dirty_match_oe_out(snoop_dirty_match_oe_out),
    .int_regs_reset_out(int_regs_reset_out),
    .fetch_reset_vector_out(fetch_reset_vector_out),
    .poweron_cfg_out(poweron_cfg_out));

  cache_bus_partner cache_bus_partner_i (.clk_sys_in(clk_sys_in),
    .srst_in(srst_in), .line_index_in(line_index_out),
    .line_writeback_in(line_writeback_out),
    .line_modified_out(line_modified_in), .line_done_out(line_done_in),
    .txn_valid_in(txn_valid_out), .txn_ready_out(txn_ready_in));

  // ************************
  // Clock, monitor, helpers
  // ************************
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    if (line_writeback_out && line_done_in) wb_cnt++;
    if (line_invalidate_out) inv_cnt++;
    if (txn_valid_out && txn_ready_in) begin
      last_code = txn_code_out;
      txn_cnt++;
    end
  end
  task automatic tick();
    @(posedge clk_sys_in);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Modified lines among the first n, odd indices in the model
  function automatic int exp_wb(input int n);
    exp_wb = n / 2;
  endfunction
  task automatic snoop(input logic h, d, b);
    snoop_req_in = 1'b1;
    {snoop_hit_in, snoop_dirty_in, snoop_busy_in} = {h, d, b};
    tick();
    chk("snoop_match", 16'(b | (h & !d)), 16'(snoop_match_out));
    chk("snoop_dirty", 16'(b | d), 16'(snoop_dirty_match_out));
    chk("snoop_oe", 16'h0003, 16'({snoop_match_oe_out,
        snoop_dirty_match_oe_out}));
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    give_verdict();
  end

  // ************************
  // Main sequence
  // ************************
  initial begin
    void'($urandom(72));
    {srst_in, id_output_gate_in, cache_purge_in} = 3'h4;
    {numeric_fault_suppress_in, warm_restart_in, bus_level_restart_in} = 3'h0;
    {cr0_numeric_report_bit_in, fp_error_in, fp_error_masked_in} = 3'h0;
    {fp_noncontrol_op_in, internal_error_in, snoop_req_in} = 3'h0;
    {snoop_hit_in, snoop_dirty_in, snoop_busy_in} = 3'h0;
    {bad_count, tests_run, wb_cnt, inv_cnt, txn_cnt} = 0;
    repeat (4) tick();
    srst_in = 1'b0;
    repeat (6) tick();
    chk("cfg_quiet", 16'h0000, 16'(poweron_cfg_out));
    chk("vid_oe_off", 16'h0000, 16'(voltage_code_oe_out));
    id_output_gate_in = 1'b1;
    repeat (6) tick();
    chk("vid_oe_on", 16'h001F, 16'(voltage_code_oe_out));
    chk("bus_ratio_select_out_oe_on", 16'h0003, 16'(bus_ratio_select_oe_out));
    chk("vid", 16'h0015, 16'(voltage_code_out));
    chk("bus_ratio_select_out", 16'h0002, 16'(bus_ratio_select_out));
    // Masked error and an idle op raise nothing
    {fp_error_in, fp_error_masked_in} = 2'h3;
    tick();
    {fp_error_in, fp_error_masked_in, fp_noncontrol_op_in} = 3'h1;
    tick();
    fp_noncontrol_op_in = 1'b0;
    chk("fexc_idle", 16'h0000, 16'(fp_exception_out));
    chk("ffault_masked", 16'h0000, 16'(float_fault_out));
    for (i = 0; i < 10; i++) begin
      sup = i < 4 ? i[0] : 1'($urandom);
      ne = i < 4 ? i[1] : 1'($urandom);
      {numeric_fault_suppress_in, cr0_numeric_report_bit_in} = {sup, ne};
      repeat (6) tick();
      fp_error_in = 1'b1;
      tick();
      fp_error_in = 1'b0;
      tick();
      chk("ffault", 16'h0001, 16'(float_fault_out));
      fp_noncontrol_op_in = 1'b1;
      tick();
      fp_noncontrol_op_in = 1'b0;
      chk("fexc", 16'(!(sup && !ne)), 16'(fp_exception_out));
      tick();
      chk("ffault_kept", 16'(sup && !ne), 16'(float_fault_out));
    end
    // Sticky internal fault, cleared by bus restart then warm restart
    for (k = 0; k < 2; k++) begin
      c0 = txn_cnt;
      internal_error_in = 1'b1;
      tick();
      internal_error_in = 1'b0;
      for (i = 0; i < 20 && txn_cnt == c0; i++) tick();
      tick();
      chk("shutdown", 16'(sideband_pkg::TXN_SHUTDOWN), 16'(last_code));
      repeat ($urandom_range(40, 10)) tick();
      chk("ifault_held", 16'h0001, 16'(internal_fault_out));
      if (k == 0) bus_level_restart_in = 1'b1;
      else warm_restart_in = 1'b1;
      repeat (6) tick();
      chk("ifault_clear", 16'h0000, 16'(internal_fault_out));
      bus_level_restart_in = 1'b0;
      // Let the synchronised bus restart fall before the next error; warm restart stays high
      repeat (6) tick();
    end
    chk("int_regs_rst", 16'h0001, 16'(int_regs_reset_out));
    for (i = 0; i < 8; i++) snoop(i[0], i[1], i[2]);
    snoop_req_in = 1'b0;
    warm_restart_in = 1'b0;
    for (i = 0; i < 8 && fetch_reset_vector_out !== 1'b1; i++) tick();
    chk("reset_vector", 16'h0001, 16'(fetch_reset_vector_out));
    // Purge walk with stalls from the model
    {wb_cnt, inv_cnt} = 0;
    c0 = txn_cnt;
    cache_purge_in = 1'b1; // held until done
    repeat (6) tick();
    chk("alloc_block", 16'h0001, 16'(cache_alloc_block_out));
    for (i = 0; i < 100 && txn_cnt == c0; i++) tick();
    tick();
    chk("flush_ack", 16'(sideband_pkg::TXN_FLUSH_ACK), 16'(last_code));
    chk("writebacks", 16'(exp_wb(4)), 16'(wb_cnt));
    chk("invalidates", 16'h0004, 16'(inv_cnt));
    repeat (5) tick();
    chk("alloc_still", 16'h0001, 16'(cache_alloc_block_out));
    cache_purge_in = 1'b0;
    repeat (6) tick();
    chk("alloc_free", 16'h0000, 16'(cache_alloc_block_out));
    // Configuration sampled at reset release
    {srst_in, cache_purge_in, warm_restart_in} = 3'h7;
    repeat (4) tick();
    srst_in = 1'b0;
    repeat (2) tick();
    chk("cfg", 16'h0003, 16'(poweron_cfg_out));
    give_verdict();
  end
endmodule // tb_cpu_sideband_error_control
